// >>> stop_pkg.sv
package stop_pkg;

	// Bus and datapath widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int SPD_W  = 16;
	localparam int OPT_W  = 4;
	localparam int SRC_N  = 4;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] A_CTRL      = 8'h00;
	localparam logic [ADDR_W-1:0] A_SPEED_REF = 8'h04;
	localparam logic [ADDR_W-1:0] A_ACC_BASE  = 8'h10;
	localparam logic [ADDR_W-1:0] A_DEC_BASE  = 8'h20;
	localparam logic [ADDR_W-1:0] A_QS_OPT    = 8'h30;
	localparam logic [ADDR_W-1:0] A_OFF_OPT   = 8'h34;
	localparam logic [ADDR_W-1:0] A_LEAVE_OPT = 8'h38;
	localparam logic [ADDR_W-1:0] A_FEED_OPT  = 8'h3c;
	localparam logic [ADDR_W-1:0] A_ERR_OPT   = 8'h40;
	localparam logic [ADDR_W-1:0] A_QS_DEC    = 8'h44;
	localparam logic [ADDR_W-1:0] A_STATUS    = 8'h48;
	localparam logic [ADDR_W-1:0] A_SPEED     = 8'h4c;

	// Field positions
	localparam int SRC_LSB    = 0;
	localparam int SRC_W      = 2;
	localparam int ST_CFG_ERR = 0;
	localparam int ST_POWER   = 1;
	localparam int ST_BRAKE   = 2;
	localparam int ST_CURRENT_LIMIT_BRAKE_DISABLE    = 3;
	localparam int ST_STATE   = 8;

	// Stop option codes
	localparam logic [OPT_W-1:0] COAST_DISABLE               = 4'h0;
	localparam logic [OPT_W-1:0] RAMP_BRAKE_DISABLE          = 4'h1;
	localparam logic [OPT_W-1:0] FAST_RAMP_BRAKE_DISABLE     = 4'h2;
	localparam logic [OPT_W-1:0] CURRENT_LIMIT_BRAKE_DISABLE = 4'h3;
	localparam logic [OPT_W-1:0] RESERVED_LOW                = 4'h4;
	localparam logic [OPT_W-1:0] RAMP_BRAKE_HOLD             = 4'h5;
	localparam logic [OPT_W-1:0] FAST_RAMP_BRAKE_HOLD        = 4'h6;
	localparam logic [OPT_W-1:0] CURRENT_LIMIT_BRAKE_HOLD    = 4'h7;
	localparam logic [OPT_W-1:0] RESERVED_HIGH               = 4'h8;

	// Reset values
	localparam logic [OPT_W-1:0] QS_OPT_RST    = FAST_RAMP_BRAKE_DISABLE;
	localparam logic [OPT_W-1:0] OFF_OPT_RST   = RAMP_BRAKE_DISABLE;
	localparam logic [OPT_W-1:0] LEAVE_OPT_RST = RAMP_BRAKE_DISABLE;
	localparam logic [OPT_W-1:0] FEED_OPT_RST  = RAMP_BRAKE_DISABLE;
	localparam logic [OPT_W-1:0] ERR_OPT_RST   = FAST_RAMP_BRAKE_DISABLE;
	localparam logic [SPD_W-1:0] QS_DEC_RST    = 16'h0bb8;
	localparam logic [SPD_W-1:0] ACC_RST       = 16'h0010;
	localparam logic [SPD_W-1:0] DEC_RST       = 16'h0010;

	// Drive states
	typedef enum logic [5:0] {
		ST_READY     = 6'b000001,
		ST_ACTIVE    = 6'b000010,
		ST_QS_BRAKE  = 6'b000100,
		ST_QS_HOLD   = 6'b001000,
		ST_DIS_BRAKE = 6'b010000,
		ST_OFF_BRAKE = 6'b100000
	} drive_state_e;

endpackage

// >>> speed_ramp.sv
module speed_ramp #(
	parameter int W = 16
) (
	input  wire logic                REF_CLK,
	input  wire logic                RST_B,
	input  wire logic signed [W-1:0] target,
	input  wire logic        [W-1:0] rate,
	input  wire logic                jump,
	output logic signed      [W-1:0] speed,
	output logic                     at_target
);

	typedef struct packed {
		logic signed [W-1:0] speed;
	} ramp_s;

	ramp_s               s_r;
	ramp_s               s_nxt;
	logic signed [W:0]   diff;
	logic signed [W:0]   rate_x;

	// Distance to target and step size, one bit wider
	assign diff   = (W+1)'(target) - (W+1)'(s_r.speed);
	assign rate_x = (W+1)'({1'b0, rate});

	// Step toward target, never overshooting
	always_comb
	begin
		s_nxt = s_r;
		if (jump)
			s_nxt.speed = target;
		else if (diff > rate_x)
			s_nxt.speed = W'((W+1)'(s_r.speed) + rate_x);
		else if (diff < -rate_x)
			s_nxt.speed = W'((W+1)'(s_r.speed) - rate_x);
		else
			s_nxt.speed = target;
	end

	// State register
	always_ff @(posedge REF_CLK or negedge RST_B)
	begin
		if (!RST_B)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign speed     = s_r.speed;
	assign at_target = (s_r.speed == target);

endmodule

// >>> stop_reaction.sv
// Local design decisions: the register offsets and the strobed register port.
module stop_reaction #(
	parameter int SRC_N = stop_pkg::SRC_N
) (
	input  wire logic                        REF_CLK,
	input  wire logic                        RST_B,
	input  wire logic [stop_pkg::ADDR_W-1:0] ADDR,
	input  wire logic [stop_pkg::DATA_W-1:0] WR_DATA,
	input  wire logic                        WR_STB,
	input  wire logic                        RD_STB,
	output logic      [stop_pkg::DATA_W-1:0] RD_DATA,
	input  wire logic                        START_REQ,
	input  wire logic                        QSTOP_REQ,
	output logic                             POWER_EN,
	output logic                             BRAKE_RELEASE,
	output logic                             CURRENT_LIMIT_BRAKE_DISABLE_ACTIVE,
	output logic                             QSTOP_STATE,
	output logic      [stop_pkg::SPD_W-1:0]  SPEED_OUT
);

	localparam int SW = stop_pkg::SPD_W;
	localparam int OW = stop_pkg::OPT_W;

	////////////////////////////////////////////////////////////////////////
	// Elaboration check

	if (SRC_N < 1 || SRC_N > 4)
	begin : g_bad_src
		$error("SRC_N must be 1 to 4");
	end

	////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		stop_pkg::drive_state_e          state;
		logic [OW-1:0]                   act_opt;
		logic [stop_pkg::SRC_W-1:0]      src;
		logic [SW-1:0]                   spd_ref;
		logic [SRC_N-1:0][SW-1:0]        acc;
		logic [SRC_N-1:0][SW-1:0]        dec;
		logic [OW-1:0]                   qs_opt;
		logic [OW-1:0]                   off_opt;
		logic [OW-1:0]                   leave_opt;
		logic [OW-1:0]                   feed_opt;
		logic [OW-1:0]                   err_opt;
		logic [SW-1:0]                   qs_dec;
		logic                            cfg_err;
		logic [stop_pkg::DATA_W-1:0]     rdata;
		logic                            qs_s1;
		logic                            qs_s2;
		logic                            run_s1;
		logic                            run_s2;
	} ctl_s;

	ctl_s                  s_r;
	ctl_s                  s_nxt;
	logic signed [SW-1:0]  ramp_target;
	logic        [SW-1:0]  ramp_rate;
	logic                  ramp_jump;
	logic signed [SW-1:0]  speed;
	logic                  at_target;
	logic [SW-1:0]         src_acc;
	logic [SW-1:0]         src_dec;
	logic                  approach;
	logic                  braking;
	logic [OW-1:0]         wr_opt;
	logic                  opt_bad;

	function automatic logic [SW-1:0] mag(input logic signed [SW-1:0] v);
		mag = v[SW-1] ? SW'(-v) : SW'(v);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Ramp selection

	// Ramp set of the selected source
	assign src_acc  = s_r.acc[s_r.src];
	assign src_dec  = s_r.dec[s_r.src];
	assign approach = (mag(SW'(s_r.spd_ref)) < mag(speed)) ||
		(s_r.spd_ref[SW-1] != speed[SW-1]);
	assign braking  = (s_r.state == stop_pkg::ST_QS_BRAKE) || (s_r.state == stop_pkg::ST_DIS_BRAKE);

	// Target, rate and jump per state; stop ramps only in stop states
	always_comb
	begin
		ramp_target = '0;
		ramp_rate   = src_dec;
		ramp_jump   = 1'b0;
		case (s_r.state)
			stop_pkg::ST_ACTIVE:
			begin
				ramp_target = SW'(s_r.spd_ref);
				ramp_rate   = approach ? src_dec : src_acc;
			end
			stop_pkg::ST_QS_BRAKE, stop_pkg::ST_DIS_BRAKE:
			begin
				case (s_r.act_opt)
					stop_pkg::RAMP_BRAKE_DISABLE, stop_pkg::RAMP_BRAKE_HOLD:
						ramp_rate = src_dec;
					stop_pkg::FAST_RAMP_BRAKE_DISABLE, stop_pkg::FAST_RAMP_BRAKE_HOLD:
						ramp_rate = s_r.qs_dec;
					default:
						ramp_jump = 1'b1;
				endcase
			end
			stop_pkg::ST_OFF_BRAKE:
				ramp_rate = src_dec;
			stop_pkg::ST_QS_HOLD:
				ramp_jump = 1'b1;
			default:
				ramp_jump = 1'b1;
		endcase
	end

	speed_ramp #(
		.W (SW)
	) u_ramp (
		.REF_CLK   (REF_CLK),
		.RST_B     (RST_B),
		.target    (ramp_target),
		.rate      (ramp_rate),
		.jump      (ramp_jump),
		.speed     (speed),
		.at_target (at_target)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state

	// Quick-stop code check on write
	assign wr_opt  = WR_DATA[OW-1:0];
	assign opt_bad = (wr_opt == stop_pkg::RESERVED_LOW) || (wr_opt >= stop_pkg::RESERVED_HIGH);

	// Synchronisers, bus slave and stop sequencer
	always_comb
	begin
		s_nxt        = s_r;
		s_nxt.qs_s1  = QSTOP_REQ;
		s_nxt.qs_s2  = s_r.qs_s1;
		s_nxt.run_s1 = START_REQ;
		s_nxt.run_s2 = s_r.run_s1;

		// Register writes
		if (WR_STB)
		begin
			case (ADDR)
				stop_pkg::A_CTRL:      s_nxt.src = WR_DATA[stop_pkg::SRC_LSB +: stop_pkg::SRC_W];
				stop_pkg::A_SPEED_REF: s_nxt.spd_ref = WR_DATA[SW-1:0];
				stop_pkg::A_QS_OPT:
				begin
					if (opt_bad)
						s_nxt.cfg_err = 1'b1;
					else
						s_nxt.qs_opt = wr_opt;
				end
				stop_pkg::A_OFF_OPT:   s_nxt.off_opt = wr_opt;
				stop_pkg::A_LEAVE_OPT: s_nxt.leave_opt = wr_opt;
				stop_pkg::A_FEED_OPT:  s_nxt.feed_opt = wr_opt;
				stop_pkg::A_ERR_OPT:   s_nxt.err_opt = wr_opt;
				stop_pkg::A_QS_DEC:    s_nxt.qs_dec = WR_DATA[SW-1:0];
				stop_pkg::A_STATUS:
					if (WR_DATA[stop_pkg::ST_CFG_ERR])
						s_nxt.cfg_err = 1'b0;
				default:
				begin
					if (ADDR[7:4] == stop_pkg::A_ACC_BASE[7:4] && 32'(ADDR[3:2]) < SRC_N)
						s_nxt.acc[ADDR[3:2]] = WR_DATA[SW-1:0];
					if (ADDR[7:4] == stop_pkg::A_DEC_BASE[7:4] && 32'(ADDR[3:2]) < SRC_N)
						s_nxt.dec[ADDR[3:2]] = WR_DATA[SW-1:0];
				end
			endcase
		end

		// Register reads, data in the next cycle only
		s_nxt.rdata = '0;
		if (RD_STB)
		begin
			case (ADDR)
				stop_pkg::A_CTRL:      s_nxt.rdata[stop_pkg::SRC_LSB +: stop_pkg::SRC_W] = s_r.src;
				stop_pkg::A_SPEED_REF: s_nxt.rdata[SW-1:0] = s_r.spd_ref;
				stop_pkg::A_QS_OPT:    s_nxt.rdata[OW-1:0] = s_r.qs_opt;
				stop_pkg::A_OFF_OPT:   s_nxt.rdata[OW-1:0] = s_r.off_opt;
				stop_pkg::A_LEAVE_OPT: s_nxt.rdata[OW-1:0] = s_r.leave_opt;
				stop_pkg::A_FEED_OPT:  s_nxt.rdata[OW-1:0] = s_r.feed_opt;
				stop_pkg::A_ERR_OPT:   s_nxt.rdata[OW-1:0] = s_r.err_opt;
				stop_pkg::A_QS_DEC:    s_nxt.rdata[SW-1:0] = s_r.qs_dec;
				stop_pkg::A_STATUS:
				begin
					s_nxt.rdata[stop_pkg::ST_CFG_ERR] = s_r.cfg_err;
					s_nxt.rdata[stop_pkg::ST_POWER]   = POWER_EN;
					s_nxt.rdata[stop_pkg::ST_BRAKE]   = BRAKE_RELEASE;
					s_nxt.rdata[stop_pkg::ST_CURRENT_LIMIT_BRAKE_DISABLE]    = CURRENT_LIMIT_BRAKE_DISABLE_ACTIVE;
					s_nxt.rdata[stop_pkg::ST_STATE +: $bits(stop_pkg::drive_state_e)] = s_r.state;
				end
				stop_pkg::A_SPEED:     s_nxt.rdata[SW-1:0] = speed;
				default:
				begin
					if (ADDR[7:4] == stop_pkg::A_ACC_BASE[7:4] && 32'(ADDR[3:2]) < SRC_N)
						s_nxt.rdata[SW-1:0] = s_r.acc[ADDR[3:2]];
					if (ADDR[7:4] == stop_pkg::A_DEC_BASE[7:4] && 32'(ADDR[3:2]) < SRC_N)
						s_nxt.rdata[SW-1:0] = s_r.dec[ADDR[3:2]];
				end
			endcase
		end

		// Stop sequencer
		case (s_r.state)
			stop_pkg::ST_READY:
				if (s_r.run_s2 && !s_r.qs_s2)
					s_nxt.state = stop_pkg::ST_ACTIVE;
			stop_pkg::ST_ACTIVE:
			begin
				if (s_r.qs_s2)
				begin
					s_nxt.act_opt = s_r.qs_opt;
					if (s_r.qs_opt == stop_pkg::COAST_DISABLE)
						s_nxt.state = stop_pkg::ST_READY;
					else if (s_r.qs_opt >= stop_pkg::RAMP_BRAKE_HOLD)
						s_nxt.state = stop_pkg::ST_QS_BRAKE;
					else
						s_nxt.state = stop_pkg::ST_DIS_BRAKE;
				end
				else if (!s_r.run_s2)
				begin
					if (s_r.off_opt == stop_pkg::COAST_DISABLE)
						s_nxt.state = stop_pkg::ST_READY;
					else
						s_nxt.state = stop_pkg::ST_OFF_BRAKE;
				end
			end
			stop_pkg::ST_QS_BRAKE:
			begin
				if (!s_r.qs_s2)
					s_nxt.state = s_r.run_s2 ? stop_pkg::ST_ACTIVE : stop_pkg::ST_READY;
				else if (at_target)
					s_nxt.state = stop_pkg::ST_QS_HOLD;
			end
			stop_pkg::ST_QS_HOLD:
				if (!s_r.qs_s2)
					s_nxt.state = stop_pkg::ST_READY;
			stop_pkg::ST_DIS_BRAKE, stop_pkg::ST_OFF_BRAKE:
				if (at_target)
					s_nxt.state = stop_pkg::ST_READY;
			default:
				s_nxt.state = stop_pkg::ST_READY;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge REF_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			s_r           <= '0;
			s_r.state     <= stop_pkg::ST_READY;
			s_r.acc       <= {SRC_N{stop_pkg::ACC_RST}};
			s_r.dec       <= {SRC_N{stop_pkg::DEC_RST}};
			s_r.qs_opt    <= stop_pkg::QS_OPT_RST;
			s_r.act_opt   <= stop_pkg::QS_OPT_RST;
			s_r.off_opt   <= stop_pkg::OFF_OPT_RST;
			s_r.leave_opt <= stop_pkg::LEAVE_OPT_RST;
			s_r.feed_opt  <= stop_pkg::FEED_OPT_RST;
			s_r.err_opt   <= stop_pkg::ERR_OPT_RST;
			s_r.qs_dec    <= stop_pkg::QS_DEC_RST;
		end
		else
			s_r <= s_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// Brake engages whenever the power stage drops
	assign POWER_EN      = (s_r.state != stop_pkg::ST_READY);
	assign BRAKE_RELEASE = POWER_EN;
	assign CURRENT_LIMIT_BRAKE_DISABLE_ACTIVE   = braking && ramp_jump;
	assign QSTOP_STATE   = braking || (s_r.state == stop_pkg::ST_QS_HOLD);
	assign SPEED_OUT     = speed;
	assign RD_DATA       = s_r.rdata;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_B);

	coast_off_a: assert property (s_r.state == stop_pkg::ST_ACTIVE && s_r.qs_s2 &&
		s_r.qs_opt == stop_pkg::COAST_DISABLE |=> !POWER_EN && !BRAKE_RELEASE)
		else $error("Coast option kept power on");
	qs_entry_a: assert property (s_r.state == stop_pkg::ST_ACTIVE && s_r.qs_s2 &&
		s_r.qs_opt != stop_pkg::COAST_DISABLE |=> QSTOP_STATE && s_r.act_opt == $past(s_r.qs_opt))
		else $error("Quick stop not entered");
	ramp_done_a: assert property (s_r.state == stop_pkg::ST_DIS_BRAKE && at_target
		|=> !POWER_EN && !BRAKE_RELEASE && s_r.state == stop_pkg::ST_READY)
		else $error("Power on after braking");
	fast_rate_a: assert property (s_r.state == stop_pkg::ST_DIS_BRAKE &&
		s_r.act_opt == stop_pkg::FAST_RAMP_BRAKE_DISABLE |-> ramp_rate == s_r.qs_dec)
		else $error("Quick-stop ramp not used");
	current_limit_brake_disable_zero_a: assert property (braking && s_r.act_opt == stop_pkg::CURRENT_LIMIT_BRAKE_DISABLE
		|=> SPEED_OUT == '0)
		else $error("Current limit stop not immediate");
	hold_zero_a: assert property (s_r.state == stop_pkg::ST_QS_HOLD |->
		SPEED_OUT == '0 && POWER_EN && QSTOP_STATE)
		else $error("Hold state not energised at zero");
	hold_stays_a: assert property (s_r.state == stop_pkg::ST_QS_HOLD && s_r.qs_s2
		|=> s_r.state == stop_pkg::ST_QS_HOLD)
		else $error("Hold left with request present");
	start_ignored_a: assert property (s_r.qs_s2 && !s_r.run_s2 &&
		(s_r.state == stop_pkg::ST_QS_BRAKE || s_r.state == stop_pkg::ST_QS_HOLD) |=> POWER_EN && QSTOP_STATE)
		else $error("Start removal acted in quick stop");
	resume_ok_a: assert property (s_r.state == stop_pkg::ST_QS_BRAKE && !s_r.qs_s2 && s_r.run_s2
		|=> s_r.state == stop_pkg::ST_ACTIVE)
		else $error("No resume during braking");
	bad_code_a: assert property (WR_STB && ADDR == stop_pkg::A_QS_OPT && opt_bad
		|=> s_r.qs_opt == $past(s_r.qs_opt) && s_r.cfg_err)
		else $error("Reserved code accepted");

endmodule

// >>> stop_host_model.sv
module stop_host_model
(
	input  wire logic REF_CLK,
	input  wire logic RST_B,
	input  wire logic start_cmd,
	input  wire logic qs_cmd,
	output logic      START_REQ,
	output logic      QSTOP_REQ
);
	timeunit 1ns;
	timeprecision 1ps;

	////////////////////////////////////////////////////////////////////////////////
	// Request levels change only just after a clock edge
	always_ff @(posedge REF_CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			START_REQ <= 1'b0;
			QSTOP_REQ <= 1'b0;
		end
		else
		begin
			START_REQ <= start_cmd;
			QSTOP_REQ <= qs_cmd; // Withdrawal ends a holding stop
		end
	end
endmodule

// >>> stop_reaction_test.sv
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end

module stop_reaction_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic                        REF_CLK = 1'b0;
	logic                        RST_B   = 1'b0;
	logic [stop_pkg::ADDR_W-1:0] ADDR    = '0;
	logic [stop_pkg::DATA_W-1:0] WR_DATA = '0;
	logic                        WR_STB  = 1'b0;
	logic                        RD_STB  = 1'b0;
	logic [stop_pkg::DATA_W-1:0] RD_DATA;
	logic                        START_REQ;
	logic                        QSTOP_REQ;
	logic                        POWER_EN;
	logic                        BRAKE_RELEASE;
	logic                        CURRENT_LIMIT_BRAKE_DISABLE_ACTIVE;
	logic                        QSTOP_STATE;
	logic [stop_pkg::SPD_W-1:0]  SPEED_OUT;
	logic                        start_cmd = 1'b0;
	logic                        qs_cmd    = 1'b0;
	int                          current_limit_brake_disable_n    = 0;
	int                          current_limit_brake_disable_0    = 0;
	logic [31:0]                 d;
	int                          errors    = 0;
	int                          checked   = 0;
	int                          n;
	logic [7:0]                  r_a [12] = '{8'h00, 8'h04, 8'h10, 8'h20, 8'h30, 8'h34, 8'h38, 8'h3c,
		8'h40, 8'h44, 8'h48, 8'h50};
	logic [31:0]                 r_d [12] = '{32'h0, 32'h0, 32'h10, 32'h10, 32'h2, 32'h1, 32'h1, 32'h1,
		32'h2, 32'h0bb8, 32'h100, 32'h0};
	logic [3:0]                  opts [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7};
	int                          lo [7]   = '{1, 128, 2, 1, 128, 2, 1};
	int                          hi [7]   = '{7, 136, 8, 7, 136, 8, 7};

	// Clock of 8 ns
	always #4 REF_CLK = ~REF_CLK;

	stop_reaction DUT
	(
		.REF_CLK       (REF_CLK),
		.RST_B         (RST_B),
		.ADDR          (ADDR),
		.WR_DATA       (WR_DATA),
		.WR_STB        (WR_STB),
		.RD_STB        (RD_STB),
		.RD_DATA       (RD_DATA),
		.START_REQ     (START_REQ),
		.QSTOP_REQ     (QSTOP_REQ),
		.POWER_EN      (POWER_EN),
		.BRAKE_RELEASE (BRAKE_RELEASE),
		.CURRENT_LIMIT_BRAKE_DISABLE_ACTIVE   (CURRENT_LIMIT_BRAKE_DISABLE_ACTIVE),
		.QSTOP_STATE   (QSTOP_STATE),
		.SPEED_OUT     (SPEED_OUT)
	);

	stop_host_model HOST
	(
		.REF_CLK   (REF_CLK),
		.RST_B     (RST_B),
		.start_cmd (start_cmd),
		.qs_cmd    (qs_cmd),
		.START_REQ (START_REQ),
		.QSTOP_REQ (QSTOP_REQ)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Notes any current-limit braking seen
	always @(posedge REF_CLK)
	begin
		if (CURRENT_LIMIT_BRAKE_DISABLE_ACTIVE === 1'b1)
			current_limit_brake_disable_n <= current_limit_brake_disable_n + 1;
	end

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge REF_CLK);
		ADDR    <= a;
		WR_DATA <= v;
		WR_STB  <= 1'b1;
		@(posedge REF_CLK);
		WR_STB  <= 1'b0;
	endtask

	// One-cycle read strobe, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge REF_CLK);
		ADDR   <= a;
		RD_STB <= 1'b1;
		@(posedge REF_CLK);
		RD_STB <= 1'b0;
		#1 v = RD_DATA;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge REF_CLK);
		#1;
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watchdog
	initial
	begin
		#400000;
		errors++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		repeat (16) @(posedge REF_CLK);
		RST_B <= 1'b1;
		wr(8'h50, 32'h5a);
		// Reset values and an unmapped place
		for (int i = 0; i < 12; i++)
		begin
			rd(r_a[i], d);
			`CHK("reg", r_d[i], d)
		end
		// Reserved quick-stop codes are refused
		wr(stop_pkg::A_QS_OPT, 32'h4);
		rd(stop_pkg::A_QS_OPT, d);
		`CHK("qs opt after 4", 32'h2, d)
		wr(stop_pkg::A_STATUS, 32'h1);
		wr(stop_pkg::A_QS_OPT, 32'h8);
		rd(stop_pkg::A_STATUS, d);
		`CHK("cfg err", 1'b1, d[0])
		wr(stop_pkg::A_STATUS, 32'h1);
		rd(stop_pkg::A_STATUS, d);
		`CHK("cfg err clear", 1'b0, d[0])
		// Source 1 with its own ramps
		wr(stop_pkg::A_CTRL, 32'h1);
		wr(stop_pkg::A_SPEED_REF, 32'h1000);
		wr(stop_pkg::A_ACC_BASE + 8'h04, 32'h1000);
		wr(stop_pkg::A_DEC_BASE + 8'h04, 32'h20);
		// Every quick-stop code
		for (int i = 0; i < 7; i++)
		begin
			wr(stop_pkg::A_QS_OPT, {28'h0, opts[i]});
			start_cmd <= 1'b1;
			cyc(10);
			`CHK("speed up", 16'h1000, SPEED_OUT)
			current_limit_brake_disable_0 = current_limit_brake_disable_n;
			qs_cmd <= 1'b1;
			n = 0;
			cyc(1);
			while (SPEED_OUT !== 16'h0 && n < 400)
			begin
				cyc(1);
				n++;
			end
			`CHK("brake cycles", 1'b1, n >= lo[i] && n <= hi[i])
			cyc(3);
			`CHK("current_limit_brake_disable seen", opts[i] == 4'h3 || opts[i] == 4'h7, current_limit_brake_disable_n != current_limit_brake_disable_0)
			if (opts[i] > 4'h4)
			begin
				`CHK("hold power", 1'b1, POWER_EN)
				start_cmd <= 1'b0;
				cyc(6);
				`CHK("hold state", 1'b1, QSTOP_STATE)
				`CHK("hold speed", 16'h0, SPEED_OUT)
				qs_cmd <= 1'b0;
				cyc(6);
				`CHK("left hold", 1'b0, QSTOP_STATE)
				`CHK("ready power", 1'b0, POWER_EN)
			end
			else
			begin
				`CHK("power off", 1'b0, POWER_EN)
				`CHK("brake on", 1'b0, BRAKE_RELEASE)
				qs_cmd    <= 1'b0;
				start_cmd <= 1'b0;
				cyc(6);
			end
		end
		// Resume during hold-type braking
		wr(stop_pkg::A_QS_OPT, 32'h5);
		start_cmd <= 1'b1;
		cyc(10);
		qs_cmd <= 1'b1;
		cyc(10);
		rd(stop_pkg::A_STATUS, d);
		`CHK("status qs brake", 32'h406, d)
		qs_cmd <= 1'b0;
		cyc(8);
		`CHK("resumed", 1'b0, QSTOP_STATE)
		`CHK("resumed power", 1'b1, POWER_EN)
		cyc(10);
		`CHK("reaccel", 16'h1000, SPEED_OUT)
		// Control off brakes on the source ramp, outside quick stop
		rd(stop_pkg::A_SPEED, d);
		`CHK("speed reg", 32'h1000, d)
		start_cmd <= 1'b0;
		n = 0;
		cyc(1);
		while (SPEED_OUT !== 16'h0 && n < 400)
		begin
			cyc(1);
			n++;
		end
		`CHK("off cycles", 1'b1, n >= 128 && n <= 136)
		`CHK("off not qs", 1'b0, QSTOP_STATE)
		cyc(3);
		`CHK("off power", 1'b0, POWER_EN)
		start_cmd <= 1'b1;
		cyc(10);
		`CHK("run again", 16'h1000, SPEED_OUT)
		// Second reset while running
		@(posedge REF_CLK);
		RST_B <= 1'b0;
		cyc(2);
		`CHK("rst power", 1'b0, POWER_EN)
		`CHK("rst speed", 16'h0, SPEED_OUT)
		start_cmd <= 1'b0;
		@(posedge REF_CLK);
		RST_B <= 1'b1;
		rd(stop_pkg::A_QS_OPT, d);
		`CHK("rst qs opt", 32'h2, d)
		report_and_stop();
	end
endmodule
